/* File: logic/cpm_pkg.sv */
/*
 * Shared constants and types of the control register map and its pointer.
 * Assumes one clock domain and a byte-wide register interface.
 */
package cpm_pkg;

	// ******************************************************************
	// Widths and depths
	// ******************************************************************
	localparam int ADDR_W     = 7;
	localparam int DATA_W     = 8;
	localparam int AUTO_BIT   = 7;
	localparam int BUF_DEPTH  = 24;
	localparam int BUF_IDX_W  = 5;
	localparam int SUBQ_DEPTH = 10;
	localparam int SUBQ_IDX_W = 4;
	localparam int CTRL_COUNT = 19;
	localparam int CTRL_IDX_W = 5;
	localparam int ID_W       = 4;

	typedef logic [DATA_W-1:0] cpm_byte_t;
	typedef logic [ADDR_W-1:0] cpm_addr_t;

	// ******************************************************************
	// Reset values and bit masks
	// ******************************************************************
	localparam cpm_byte_t PTR_RESET  = 8'h01;
	localparam cpm_byte_t REG_RESET  = 8'h00;
	localparam cpm_byte_t ZERO_BYTE  = 8'h00;
	localparam cpm_byte_t ALL_BITS   = 8'hff;
	localparam cpm_byte_t LOW7_BITS  = 8'h7f;
	localparam cpm_byte_t LOW6_BITS  = 8'h3f;
	localparam cpm_byte_t LOW5_BITS  = 8'h1f;

	// ******************************************************************
	// Register addresses
	// ******************************************************************
	localparam cpm_addr_t A_RSV_LOW    = 7'h00;
	localparam cpm_addr_t A_MISC1      = 7'h01;
	localparam cpm_addr_t A_MISC2      = 7'h02;
	localparam cpm_addr_t A_ROUTE      = 7'h03;
	localparam cpm_addr_t A_CLKSEL     = 7'h04;
	localparam cpm_addr_t A_SIN_FMT    = 7'h05;
	localparam cpm_addr_t A_SOUT_FMT   = 7'h06;
	localparam cpm_addr_t A_EVT1       = 7'h07;
	localparam cpm_addr_t A_EVT2       = 7'h08;
	localparam cpm_addr_t A_EMASK1     = 7'h09;
	localparam cpm_addr_t A_ETRIG1_HI  = 7'h0a;
	localparam cpm_addr_t A_ETRIG1_LO  = 7'h0b;
	localparam cpm_addr_t A_EMASK2     = 7'h0c;
	localparam cpm_addr_t A_ETRIG2_HI  = 7'h0d;
	localparam cpm_addr_t A_ETRIG2_LO  = 7'h0e;
	localparam cpm_addr_t A_RX_STATUS  = 7'h0f;
	localparam cpm_addr_t A_RX_ERR     = 7'h10;
	localparam cpm_addr_t A_RX_EMASK   = 7'h11;
	localparam cpm_addr_t A_STBUF_CTL  = 7'h12;
	localparam cpm_addr_t A_UBUF_CTL   = 7'h13;
	localparam cpm_addr_t A_SUBQ_FIRST = 7'h14;
	localparam cpm_addr_t A_SUBQ_LAST  = 7'h1d;
	localparam cpm_addr_t A_RATIO      = 7'h1e;
	localparam cpm_addr_t A_RSV_MID    = 7'h1f;
	localparam cpm_addr_t A_BUF_FIRST  = 7'h20;
	localparam cpm_addr_t A_BUF_LAST   = 7'h37;
	localparam cpm_addr_t A_RSV_HIGH   = 7'h38;
	localparam cpm_addr_t A_RSV_TOP    = 7'h7e;
	localparam cpm_addr_t A_ID         = 7'h7f;

	// Bits that exist in each control-range register; the rest read zero
	function automatic cpm_byte_t cpm_valid_bits(input cpm_addr_t a);
		case (a)
			A_CLKSEL, A_RX_ERR, A_RX_EMASK:          return LOW7_BITS;
			A_EVT2, A_EMASK2, A_ETRIG2_HI,
			A_ETRIG2_LO, A_STBUF_CTL:                return LOW6_BITS;
			A_UBUF_CTL:                              return LOW5_BITS;
			default:                                 return ALL_BITS;
		endcase
	endfunction : cpm_valid_bits

	// Control-range registers that the host may write
	function automatic logic cpm_writable(input cpm_addr_t a);
		case (a)
			A_MISC1, A_MISC2, A_ROUTE, A_CLKSEL, A_SIN_FMT, A_SOUT_FMT,
			A_EMASK1, A_ETRIG1_HI, A_ETRIG1_LO, A_EMASK2, A_ETRIG2_HI,
			A_ETRIG2_LO, A_RX_EMASK, A_STBUF_CTL, A_UBUF_CTL: return 1'b1;
			default:                                          return 1'b0;
		endcase
	endfunction : cpm_writable

endpackage : cpm_pkg

/* File: logic/cpm_ptr_if.sv */
/*
 * Carrier between the register map and its pointer unit.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/1ns
interface cpm_ptr_if;
	import cpm_pkg::*;

	logic      load;
	cpm_byte_t load_value;
	logic      xfer;
	cpm_byte_t value;

	modport owner (input load, input load_value, input xfer, output value);
	modport user  (output load, output load_value, output xfer, input value);
endinterface : cpm_ptr_if

/* File: logic/cpm_pointer.sv */
/*
 * Register pointer: auto-step flag over a seven-bit register address.
 * Assumes the map raises xfer for one cycle per data byte moved.
 */
`timescale 1ns/1ns
module cpm_pointer
	import cpm_pkg::*;
(
	input  wire logic clock_in,
	input  wire logic sys_rst_in,
	cpm_ptr_if.owner  ptr_bus
);

	// ******************************************************************
	// Pointer register
	// ******************************************************************
	cpm_byte_t value_ff;
	cpm_byte_t nxt_value;
	logic      auto_step_flag;
	cpm_addr_t pointer_address_field;
	cpm_addr_t stepped_address;

	assign auto_step_flag        = value_ff[AUTO_BIT];
	assign pointer_address_field = value_ff[ADDR_W-1:0];
	assign stepped_address       = cpm_addr_t'(pointer_address_field + 1'b1);
	// Held when the flag is clear, one up per byte when it is set
	assign nxt_value = ptr_bus.load ? ptr_bus.load_value :
		(ptr_bus.xfer && auto_step_flag) ?
		{auto_step_flag, stepped_address} :
		value_ff;

	always_ff @(posedge clock_in) begin
		if (sys_rst_in) begin
			value_ff <= PTR_RESET;
		end else begin
			value_ff <= nxt_value;
		end
	end

	assign ptr_bus.value = value_ff;

	// ******************************************************************
	// Checks
	// ******************************************************************
	default clocking cb @(posedge clock_in); endclocking
	default disable iff (sys_rst_in);

	sequence seq_plain_xfer;
		ptr_bus.xfer && !ptr_bus.load;
	endsequence

	chk_ptr_reset: assert property (
		$fell(sys_rst_in) |-> value_ff == PTR_RESET)
		else $error("pointer not at default after reset");

	chk_addr_hold: assert property (
		seq_plain_xfer and !auto_step_flag |=> $stable(value_ff))
		else $error("pointer moved with auto-step off");

	chk_addr_step: assert property (
		seq_plain_xfer and auto_step_flag |=>
		pointer_address_field ==
		cpm_addr_t'($past(pointer_address_field) + 1'b1))
		else $error("pointer did not step by one");

	chk_flag_keep: assert property (
		seq_plain_xfer |=> auto_step_flag == $past(auto_step_flag))
		else $error("auto-step flag changed on a data byte");

endmodule : cpm_pointer

/* File: logic/cpm_regmap.sv */
/*
 * Control register bank reached through an auto-stepping register pointer.
 * Assumes a serial control port front end on the same clock that delivers
 * one pointer byte, then data bytes, as single-cycle strobes, and core
 * logic on the same clock that supplies the read-only status values.
 */
`timescale 1ns/1ns

module cpm_regmap
	import cpm_pkg::*;
#(
	parameter logic [ID_W-1:0] ID_CODE      = 4'h5, // Arbitrary value
	parameter logic [ID_W-1:0] VERSION_CODE = 4'h1  // Arbitrary value
) (
	input  wire logic                    clock_in,
	input  wire logic                    sys_rst_in,
	// Byte strobes from the control port front end
	input  wire logic                    ptr_wr_in,
	input  wire logic                    data_wr_in,
	input  wire logic                    data_rd_in,
	input  wire cpm_byte_t               wr_byte_in,
	output      cpm_byte_t               rd_data_out,
	output      logic                    rd_valid_out,
	output      cpm_byte_t               pointer_out,
	output      logic                    rsv_hit_out,
	// Status values from the core
	input  wire cpm_byte_t               event_flags_one_in,
	input  wire cpm_byte_t               event_flags_two_in,
	input  wire cpm_byte_t               received_status_bits_in,
	input  wire cpm_byte_t               receive_error_flags_in,
	input  wire cpm_byte_t [SUBQ_DEPTH-1:0] subcode_bytes_in,
	input  wire cpm_byte_t               rate_ratio_in,
	// Control values to the core
	output      cpm_byte_t [CTRL_COUNT:1] control_regs_out,
	// Core access to the status/user buffer
	input  wire logic                    core_buf_we_in,
	input  wire logic [BUF_IDX_W-1:0]    core_buf_wr_idx_in,
	input  wire cpm_byte_t               core_buf_wr_data_in,
	input  wire logic [BUF_IDX_W-1:0]    core_buf_rd_idx_in,
	output      cpm_byte_t               core_buf_rd_data_out
);

	// ******************************************************************
	// Pointer
	// ******************************************************************
	cpm_ptr_if ptr_bus ();

	logic      host_wr;
	logic      rd_req;
	cpm_addr_t addr;

	// Pointer byte wins; a write wins over a read in the same cycle
	assign host_wr = data_wr_in && !ptr_wr_in;
	assign rd_req  = data_rd_in && !ptr_wr_in && !data_wr_in;

	assign ptr_bus.load       = ptr_wr_in;
	assign ptr_bus.load_value = wr_byte_in;
	assign ptr_bus.xfer       = host_wr || rd_req;

	cpm_pointer u_pointer (
		.clock_in   (clock_in),
		.sys_rst_in (sys_rst_in),
		.ptr_bus    (ptr_bus)
	);

	assign addr        = ptr_bus.value[ADDR_W-1:0];
	assign pointer_out = ptr_bus.value;

	// ******************************************************************
	// Address decode
	// ******************************************************************
	logic                  is_ctrl;
	logic                  is_subq;
	logic                  is_buf;
	logic                  is_rsv;
	logic                  ctrl_rw;
	logic                  ctrl_we;
	logic                  buf_we;
	cpm_byte_t             vbits;
	cpm_addr_t             ctrl_off;
	cpm_addr_t             subq_off;
	cpm_addr_t             buf_off;
	logic [CTRL_IDX_W-1:0] ctrl_idx;
	logic [SUBQ_IDX_W-1:0] subq_idx;
	logic [BUF_IDX_W-1:0]  buf_idx;

	assign is_ctrl = (addr >= A_MISC1) && (addr <= A_UBUF_CTL);
	assign is_subq = (addr >= A_SUBQ_FIRST) && (addr <= A_SUBQ_LAST);
	assign is_buf  = (addr >= A_BUF_FIRST) && (addr <= A_BUF_LAST);
	assign is_rsv  = (addr == A_RSV_LOW) || (addr == A_RSV_MID) ||
		((addr >= A_RSV_HIGH) && (addr <= A_RSV_TOP));

	assign ctrl_rw  = is_ctrl && cpm_writable(addr);
	assign vbits    = cpm_valid_bits(addr);
	assign ctrl_off = addr;
	assign subq_off = cpm_addr_t'(addr - A_SUBQ_FIRST);
	assign buf_off  = cpm_addr_t'(addr - A_BUF_FIRST);
	assign ctrl_idx = ctrl_off[CTRL_IDX_W-1:0];
	assign subq_idx = subq_off[SUBQ_IDX_W-1:0];
	assign buf_idx  = buf_off[BUF_IDX_W-1:0];

	// Reserved and read-only targets never take a write
	assign ctrl_we = host_wr && ctrl_rw;
	assign buf_we  = host_wr && is_buf;

	// ******************************************************************
	// Control registers
	// ******************************************************************
	cpm_byte_t [CTRL_COUNT:1] ctrl_ff;
	cpm_byte_t                nxt_ctrl_byte;
	cpm_byte_t                ctrl_sel;

	assign ctrl_sel      = is_ctrl ? ctrl_ff[ctrl_idx] : ZERO_BYTE;
	assign nxt_ctrl_byte = (wr_byte_in & vbits) | (ctrl_sel & ~vbits);

	always_ff @(posedge clock_in) begin
		if (sys_rst_in) begin
			ctrl_ff <= {CTRL_COUNT{REG_RESET}};
		end else if (ctrl_we) begin
			ctrl_ff[ctrl_idx] <= nxt_ctrl_byte;
		end
	end

	assign control_regs_out = ctrl_ff;

	// ******************************************************************
	// Status/user buffer
	// ******************************************************************
	cpm_byte_t buf_mem_ff [BUF_DEPTH];
	cpm_byte_t core_rd_ff;
	cpm_byte_t buf_sel;
	logic      core_wr_ok;
	logic      host_buf_hit;

	assign core_wr_ok   = core_buf_we_in && (core_buf_wr_idx_in < BUF_DEPTH);
	// The core's update of the same byte wins over the host's
	assign host_buf_hit = buf_we &&
		!(core_wr_ok && (core_buf_wr_idx_in == buf_idx));
	assign buf_sel      = is_buf ? buf_mem_ff[buf_idx] : ZERO_BYTE;

	always_ff @(posedge clock_in) begin
		if (sys_rst_in) begin
			for (int i = 0; i < BUF_DEPTH; i++) begin
				buf_mem_ff[i] <= REG_RESET;
			end
		end else begin
			if (host_buf_hit) begin
				buf_mem_ff[buf_idx] <= wr_byte_in;
			end
			if (core_wr_ok) begin
				buf_mem_ff[core_buf_wr_idx_in] <= core_buf_wr_data_in;
			end
		end
	end

	always_ff @(posedge clock_in) begin
		if (sys_rst_in) begin
			core_rd_ff <= ZERO_BYTE;
		end else if (core_buf_rd_idx_in < BUF_DEPTH) begin
			core_rd_ff <= buf_mem_ff[core_buf_rd_idx_in];
		end else begin
			core_rd_ff <= ZERO_BYTE;
		end
	end

	assign core_buf_rd_data_out = core_rd_ff;

	// ******************************************************************
	// Read path
	// ******************************************************************
	cpm_byte_t subq_sel;
	cpm_byte_t ident_byte;
	cpm_byte_t rd_mux;
	cpm_byte_t rd_data_ff;
	logic      rd_valid_ff;
	logic      rsv_hit_ff;

	assign subq_sel   = is_subq ? subcode_bytes_in[subq_idx] : ZERO_BYTE;
	assign ident_byte = {ID_CODE, VERSION_CODE};

	assign rd_mux =
		ctrl_rw                    ? ctrl_sel & vbits :
		(addr == A_EVT1)           ? event_flags_one_in & vbits :
		(addr == A_EVT2)           ? event_flags_two_in & vbits :
		(addr == A_RX_STATUS)      ? received_status_bits_in & vbits :
		(addr == A_RX_ERR)         ? receive_error_flags_in & vbits :
		is_subq                    ? subq_sel :
		(addr == A_RATIO)          ? rate_ratio_in :
		is_buf                     ? buf_sel :
		(addr == A_ID)             ? ident_byte :
		ZERO_BYTE;

	always_ff @(posedge clock_in) begin
		if (sys_rst_in) begin
			rd_data_ff  <= ZERO_BYTE;
			rd_valid_ff <= 1'b0;
			rsv_hit_ff  <= 1'b0;
		end else begin
			if (rd_req) begin
				rd_data_ff <= rd_mux;
			end
			rd_valid_ff <= rd_req;
			rsv_hit_ff  <= host_wr && is_rsv;
		end
	end

	assign rd_data_out  = rd_data_ff;
	assign rd_valid_out = rd_valid_ff;
	assign rsv_hit_out  = rsv_hit_ff;

	// ******************************************************************
	// Checks
	// ******************************************************************
	default clocking cb @(posedge clock_in); endclocking
	default disable iff (sys_rst_in);

	sequence seq_read_at(cpm_addr_t a);
		rd_req && (addr == a);
	endsequence

	sequence seq_buf_write_then_read;
		host_buf_hit && !core_buf_we_in && !ptr_bus.value[AUTO_BIT]
		##1 rd_req;
	endsequence

	chk_ratio_read: assert property (
		seq_read_at(A_RATIO) |=>
		rd_valid_out && (rd_data_out == $past(rate_ratio_in)))
		else $error("rate ratio read returned wrong byte");

	chk_ident_read: assert property (
		seq_read_at(A_ID) |=>
		rd_valid_out && (rd_data_out == {ID_CODE, VERSION_CODE}))
		else $error("identity read returned wrong byte");

	chk_rsv_ignore: assert property (
		host_wr && is_rsv |=> rsv_hit_out && $stable(ctrl_ff))
		else $error("reserved write altered control state");

	chk_rsv_zero: assert property (
		rd_req && is_rsv |=> rd_valid_out && (rd_data_out == ZERO_BYTE))
		else $error("reserved read not zero");

	chk_subq_read: assert property (
		rd_req && is_subq |=>
		rd_data_out ==
		$past(subcode_bytes_in[SUBQ_IDX_W'(addr - A_SUBQ_FIRST)]))
		else $error("subcode read returned wrong byte");

	chk_buf_readback: assert property (
		seq_buf_write_then_read |=> rd_data_out == $past(wr_byte_in, 2))
		else $error("buffer byte not read back");

	chk_ctrl_write: assert property (
		ctrl_we |=> control_regs_out[$past(ctrl_idx)] ==
		($past(wr_byte_in) & $past(vbits)))
		else $error("control write not stored");

	sequence seq_no_access;
		!ptr_wr_in && !data_wr_in && !data_rd_in;
	endsequence

	chk_rd_pulse: assert property (
		!rd_req |=>
		!rd_valid_out)
		else $error("read valid without a read");

	chk_rd_hold: assert property (
		!rd_req |=>
		$stable(rd_data_out))
		else $error("read data moved without a read");

	chk_write_noread: assert property (
		host_wr |=>
		!rd_valid_out)
		else $error("write also answered as a read");

	chk_evt1_read: assert property (
		seq_read_at(A_EVT1) |=>
		rd_data_out == $past(event_flags_one_in))
		else $error("event flags one read wrong");

	chk_evt2_read: assert property (
		seq_read_at(A_EVT2) |=>
		rd_data_out == ($past(event_flags_two_in) & LOW6_BITS))
		else $error("event flags two read wrong");

	chk_rxstat_read: assert property (
		seq_read_at(A_RX_STATUS) |=>
		rd_data_out == $past(received_status_bits_in))
		else $error("received status read wrong");

	chk_rxerr_read: assert property (
		seq_read_at(A_RX_ERR) |=>
		rd_data_out == ($past(receive_error_flags_in) & LOW7_BITS))
		else $error("receive error read wrong");

	chk_ptr_load: assert property (
		ptr_wr_in |=>
		pointer_out == $past(wr_byte_in))
		else $error("pointer byte not loaded");

	chk_ptr_idle: assert property (
		seq_no_access |=>
		$stable(pointer_out))
		else $error("pointer moved without a byte");

	chk_read_step: assert property (
		rd_req && pointer_out[AUTO_BIT] |=>
		pointer_out[ADDR_W-1:0] ==
		cpm_addr_t'($past(pointer_out[ADDR_W-1:0]) + 1'b1))
		else $error("pointer did not step after a read");

	chk_ro_ignore: assert property (
		host_wr && !ctrl_rw |=>
		$stable(control_regs_out))
		else $error("control state moved on a foreign write");

	chk_clksel_bits: assert property (
		(control_regs_out[A_CLKSEL] & ~LOW7_BITS) ==
		ZERO_BYTE)
		else $error("clock select top bit not zero");

	chk_ubuf_bits: assert property (
		(control_regs_out[A_UBUF_CTL] & ~LOW5_BITS) ==
		ZERO_BYTE)
		else $error("user buffer control top bits not zero");

	chk_rsv_pulse: assert property (
		!(host_wr && is_rsv) |=>
		!rsv_hit_out)
		else $error("reserved flag without reserved write");

	chk_buf_write: assert property (
		host_buf_hit |=>
		buf_mem_ff[$past(buf_idx)] == $past(wr_byte_in))
		else $error("buffer byte not stored");

endmodule : cpm_regmap

/* File: tb/cpm_host_model.sv */
/*
 * Host model of the serial control port: pointer bytes, data bytes, reads.
 * Assumes callers enter each task just after a rising clock edge.
 */
`timescale 1ns/1ns
module cpm_host_model
	import cpm_pkg::*;
(
	input  wire logic      clock_in,
	output      logic      ptr_wr_out,
	output      logic      data_wr_out,
	output      logic      data_rd_out,
	output      cpm_byte_t wr_byte_out,
	input  wire cpm_byte_t rd_data_in,
	input  wire logic      rd_valid_in
);
	cpm_byte_t shadow_ptr;
	cpm_byte_t last_rd;
	logic      last_vld;

	initial begin
		ptr_wr_out  = 1'b0;
		data_wr_out = 1'b0;
		data_rd_out = 1'b0;
		wr_byte_out = 8'h00;
		shadow_ptr  = 8'h01;
	end

	// Released data line shows the inverse of the last byte; an idle edge
	// follows each strobe so no line is driven twice in one time step
	task strobe(input int kind, input cpm_byte_t b);
		ptr_wr_out  = (kind == 0);
		data_wr_out = (kind == 1);
		data_rd_out = (kind == 2);
		wr_byte_out = b;
		@(posedge clock_in);
		#1;
		last_rd     = rd_data_in;
		last_vld    = rd_valid_in;
		ptr_wr_out  = 1'b0;
		data_wr_out = 1'b0;
		data_rd_out = 1'b0;
		wr_byte_out = ~b;
		if (kind != 0 && shadow_ptr[7]) begin
			shadow_ptr[6:0] = shadow_ptr[6:0] + 7'h01;
		end
		@(posedge clock_in);
		#1;
	endtask : strobe

	task put_ptr(input cpm_byte_t b);
		shadow_ptr = b;
		strobe(0, b);
	endtask : put_ptr

	task put_data(input cpm_byte_t b);
		logic [6:0] a;
		a = shadow_ptr[6:0];
		if (a == 7'h00 || a == 7'h1f || a >= 7'h38 && a <= 7'h7e) begin
			return;
		end
		strobe(1, b);
	endtask : put_data

	task get_data(output cpm_byte_t b, output logic v);
		strobe(2, ~wr_byte_out);
		b = last_rd;
		v = last_vld;
	endtask : get_data

	// Data write, then a read on the very next edge; caller keeps the
	// pointer on a writable address
	task put_get(input cpm_byte_t b, output cpm_byte_t g, output logic v);
		data_wr_out = 1'b1;
		wr_byte_out = b;
		@(posedge clock_in);
		#1;
		data_wr_out = 1'b0;
		data_rd_out = 1'b1;
		@(posedge clock_in);
		#1;
		g           = rd_data_in;
		v           = rd_valid_in;
		data_rd_out = 1'b0;
		wr_byte_out = ~b;
		if (shadow_ptr[7]) begin
			shadow_ptr[6:0] = shadow_ptr[6:0] + 7'h02;
		end
		@(posedge clock_in);
		#1;
	endtask : put_get
endmodule : cpm_host_model

/* File: tb/control_register_map_pointer_tb.sv */
/*
 * Self-checking bench of the register map against a reference model.
 * Assumes the host model drives the register port; bench drives the core.
 */
`timescale 1ns/1ns
module control_register_map_pointer_tb;
	import cpm_pkg::*;

	localparam logic [3:0] ID_V  = 4'ha; // Arbitrary value
	localparam logic [3:0] VER_V = 4'h3; // Arbitrary value

	logic                      clock_in = 1'b0;
	logic                      sys_rst_in = 1'b1;
	logic                      ptr_wr, data_wr, data_rd, rd_valid, rsv_hit;
	cpm_byte_t                 wr_byte, rd_data, pointer;
	cpm_byte_t                 ev1 = 8'h00, ev2 = 8'h00, rxs = 8'h00;
	cpm_byte_t                 rxe = 8'h00, ratio = 8'h00, cb_wd = 8'h00;
	cpm_byte_t                 cb_rd;
	cpm_byte_t [SUBQ_DEPTH-1:0] subq = '0;
	cpm_byte_t [CTRL_COUNT:1]  ctrl;
	logic                      cb_we = 1'b0;
	logic [BUF_IDX_W-1:0]      cb_wi = 5'h00, cb_ri = 5'h00;
	int                        err_count = 0, n_tests = 0, mp, mem[128];
	bit                        rsv_seen = 1'b0;
	cpm_byte_t                 got;
	logic                      vld;

	always #4 clock_in = ~clock_in;
	always @(posedge clock_in) if (rsv_hit === 1'b1) rsv_seen <= 1'b1;

	cpm_regmap #(.ID_CODE(ID_V), .VERSION_CODE(VER_V)) u_dut (
		.clock_in(clock_in), .sys_rst_in(sys_rst_in),
		.ptr_wr_in(ptr_wr), .data_wr_in(data_wr), .data_rd_in(data_rd),
		.wr_byte_in(wr_byte), .rd_data_out(rd_data),
		.rd_valid_out(rd_valid), .pointer_out(pointer),
		.rsv_hit_out(rsv_hit), .event_flags_one_in(ev1),
		.event_flags_two_in(ev2), .received_status_bits_in(rxs),
		.receive_error_flags_in(rxe), .subcode_bytes_in(subq),
		.rate_ratio_in(ratio), .control_regs_out(ctrl),
		.core_buf_we_in(cb_we), .core_buf_wr_idx_in(cb_wi),
		.core_buf_wr_data_in(cb_wd), .core_buf_rd_idx_in(cb_ri),
		.core_buf_rd_data_out(cb_rd));

	cpm_host_model u_host (
		.clock_in(clock_in), .ptr_wr_out(ptr_wr), .data_wr_out(data_wr),
		.data_rd_out(data_rd), .wr_byte_out(wr_byte),
		.rd_data_in(rd_data), .rd_valid_in(rd_valid));

	// ******************************************************************
	// Reference model
	// ******************************************************************
	function automatic int mask_of(int a);
		case (a)
			4, 16, 17:          return 'h7f;
			8, 12, 13, 14, 18:  return 'h3f;
			19:                 return 'h1f;
			default:            return 'hff;
		endcase
	endfunction : mask_of

	function automatic bit can_wr(int a);
		return (a >= 1 && a <= 19 && !(a inside {7, 8, 15, 16})) ||
			(a >= 32 && a <= 55);
	endfunction : can_wr

	function automatic int exp_rd(int a);
		case (a)
			7:       return ev1 & mask_of(a);
			8:       return ev2 & mask_of(a);
			15:      return rxs;
			16:      return rxe & mask_of(a);
			30:      return ratio;
			127:     return {ID_V, VER_V};
			default: begin
				if (a >= 20 && a <= 29) return subq[a-20];
				return mem[a];
			end
		endcase
	endfunction : exp_rd

	task cmp(input logic [7:0] g, input logic [7:0] e);
		n_tests++;
		if (g !== e) begin
			err_count++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : cmp

	task step();
		if (mp >= 'h80) mp = 'h80 | ((mp + 1) & 'h7f);
	endtask : step

	task do_ptr(input int b);
		u_host.put_ptr(b[7:0]);
		mp = b;
		cmp(pointer, b[7:0]);
	endtask : do_ptr

	task do_wr(input int v);
		u_host.put_data(v[7:0]);
		if (can_wr(mp & 'h7f)) mem[mp & 'h7f] = v & mask_of(mp & 'h7f);
		step();
		cmp(pointer, mp[7:0]);
	endtask : do_wr

	task do_rd();
		int e;
		e = exp_rd(mp & 'h7f);
		u_host.get_data(got, vld);
		cmp({7'h00, vld}, 8'h01);
		cmp(got, e[7:0]);
		step();
		cmp(pointer, mp[7:0]);
	endtask : do_rd

	task do_wr_rd(input int v);
		u_host.put_get(v[7:0], got, vld);
		mem[mp & 'h7f] = v & 'hff;
		cmp({7'h00, vld}, 8'h01);
		cmp(got, v[7:0]);
		cmp(pointer, mp[7:0]);
	endtask : do_wr_rd

	task summarize();
		$display("checks=%0d mismatches=%0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : summarize

	initial begin
		#100000;
		err_count++;
		summarize();
	end

	// ******************************************************************
	// Tests
	// ******************************************************************
	initial begin
		foreach (mem[i]) mem[i] = 0;
		void'($urandom(68));
		repeat (16) @(posedge clock_in);
		#1;
		sys_rst_in = 1'b0;
		ev1 = 8'($urandom);
		ev2 = 8'($urandom);
		rxs = 8'($urandom);
		rxe = 8'($urandom);
		ratio = 8'($urandom);
		foreach (subq[k]) subq[k] = 8'($urandom);
		cmp(pointer, 8'h01);
		for (int a = 1; a <= 19; a++) cmp(ctrl[a], 8'h00);
		mp = 'h01;
		$display("test reset done");
		do_ptr('h02);
		repeat (2) do_wr($urandom);
		repeat (2) do_rd();
		$display("test fixed pointer done");
		do_ptr('h81);
		for (int a = 1; a <= 19; a++) do_wr($urandom);
		for (int a = 1; a <= 19; a++) cmp(ctrl[a], mem[a][7:0]);
		do_ptr('h81);
		repeat (30) do_rd();
		$display("test control block done");
		do_ptr('ha0);
		repeat (24) do_wr($urandom);
		@(posedge clock_in);
		#1;
		cb_we = 1'b1;
		cb_wi = 5'h03;
		cb_wd = 8'($urandom);
		cb_ri = 5'h05;
		@(posedge clock_in);
		#1;
		cb_we = 1'b0;
		mem[35] = cb_wd;
		cmp(cb_rd, mem[37][7:0]);
		do_ptr('h25);
		repeat (2) do_wr_rd($urandom);
		do_ptr('h9f);
		repeat (25) do_rd();
		$display("test buffer done");
		do_ptr('h80);
		do_rd();
		do_ptr('hb8);
		do_rd();
		do_ptr('hfe);
		repeat (3) do_rd();
		do_ptr('h7f);
		repeat (2) do_rd();
		cmp({7'h00, rsv_seen}, 8'h00);
		$display("test reserved and identity done");
		summarize();
	end
endmodule : control_register_map_pointer_tb
